/* common/perit_pkg.sv */
package perit_pkg;

    // ------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 5;
    localparam int DATA_W = 32;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_CNT_HI = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_CNT_LO = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_MOD_HI = 5'h0c;
    localparam logic [ADDR_W-1:0] OFS_MOD_LO = 5'h10;

    // ------------------------------------------------------------
    // Status and control field positions
    // ------------------------------------------------------------
    localparam int BIT_FLAG = 7;
    localparam int BIT_IE   = 6;
    localparam int BIT_HALT = 5;
    localparam int BIT_CLR  = 4;
    localparam int PS_LSB   = 0;
    localparam int PS_W     = 3;

    // ------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------
    localparam int              CNT_W    = 16;
    localparam int              PRE_W    = 6;
    localparam logic            RST_IE   = 1'b0;
    localparam logic            RST_HALT = 1'b1;
    localparam logic [PS_W-1:0] RST_PS   = 3'h0;
    localparam logic [PS_W-1:0] PS_MAX   = 3'h6;
    localparam logic [CNT_W-1:0] RST_MOD = 16'hffff;
    localparam logic [CNT_W-1:0] RST_CNT = 16'h0000;
    localparam logic [PRE_W-1:0] RST_PRE = 6'h00;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic            ie;
        logic            halt;
        logic [PS_W-1:0] ps;
    } perit_ctrl_t;

    typedef enum logic [1:0] {
        BUS_IDLE   = 2'b01,
        BUS_ANSWER = 2'b10
    } perit_bus_state_t;

endpackage

/* src/perit_prescaler.sv */
`timescale 1ns/1ps
module perit_prescaler (
    input  wire logic                       i_clk,
    input  wire logic                       i_reset,
    input  wire logic                       i_clear,
    input  wire logic                       i_run,
    input  wire logic [perit_pkg::PS_W-1:0] i_sel,
    output logic                            o_tick
);
    import perit_pkg::*;

    logic [PRE_W-1:0] div_r;
    logic [PRE_W-1:0] div_nxt;
    logic [PRE_W-1:0] mask;
    logic [PS_W-1:0]  sel_eff;

    // Code 7 behaves as divide by 64
    assign sel_eff = (i_sel > PS_MAX) ? PS_MAX : i_sel;

    // Low bits that must all be set for a tick
    genvar gi;
    generate
        for (gi = 0; gi < PRE_W; gi = gi + 1) begin : g_mask
            assign mask[gi] = (PS_W'(gi) < sel_eff);
        end
    endgenerate

    assign o_tick  = i_run & ((div_r & mask) == mask);
    assign div_nxt = i_clear ? RST_PRE : (i_run ? div_r + 6'h01 : div_r);

    // Divider chain
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            div_r <= RST_PRE;
        end else begin
            div_r <= div_nxt;
        end
    end
endmodule

/* src/perit_counter.sv */
`timescale 1ns/1ps
module perit_counter (
    input  wire logic                        i_clk,
    input  wire logic                        i_reset,
    input  wire logic                        i_clear,
    input  wire logic                        i_tick,
    input  wire logic [perit_pkg::CNT_W-1:0] i_modulo,
    output logic      [perit_pkg::CNT_W-1:0] o_count,
    output logic                             o_reach
);
    import perit_pkg::*;

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_step;
    logic [CNT_W-1:0] cnt_nxt;

    // Wrap to zero on the tick after a match
    assign cnt_step = (cnt_r == i_modulo) ? RST_CNT : cnt_r + 16'h0001;
    assign cnt_nxt  = i_clear ? RST_CNT : (i_tick ? cnt_step : cnt_r);
    assign o_reach  = i_tick & ~i_clear & (cnt_step == i_modulo);
    assign o_count  = cnt_r;

    // Count register
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            cnt_r <= RST_CNT;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule

/* src/perit_timer.sv */
// Local design decisions: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
module perit_timer (
    input  wire logic                         i_clk,
    input  wire logic                         i_reset,
    // Avalon-MM slave
    input  wire logic [perit_pkg::ADDR_W-1:0] i_avs_address,
    input  wire logic                         i_avs_read,
    input  wire logic                         i_avs_write,
    input  wire logic [perit_pkg::DATA_W-1:0] i_avs_writedata,
    input  wire logic [3:0]                   i_avs_byteenable,
    output logic      [perit_pkg::DATA_W-1:0] o_avs_readdata,
    output logic                              o_avs_waitrequest,
    // System state inputs
    input  wire logic                         i_wait_mode,
    input  wire logic                         i_stop_mode,
    input  wire logic                         i_break,
    input  wire logic                         i_break_clear_enable,
    // Interrupt request
    output logic                              o_irq
);
    import perit_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    perit_bus_state_t bus_state_r;
    perit_bus_state_t bus_state_nxt;
    perit_ctrl_t      ctrl_r;
    perit_ctrl_t      ctrl_nxt;

    logic [DATA_W-1:0] readdata_r;
    logic [DATA_W-1:0] rd_mux;
    logic [CNT_W-1:0]  snap_r;
    logic [7:0]        lo_buf_r;
    logic              lo_held_r;
    logic [7:0]        mod_hi_r;
    logic [7:0]        mod_lo_r;
    logic              inhibit_r;
    logic              flag_r;
    logic              flag_nxt;
    logic              arm_r;
    logic              arm_nxt;
    logic              seen_flag_r;
    logic              arm_set;
    logic              arm_drop;

    logic              req;
    logic              answer;
    logic              capture;
    logic              acc_ok;
    logic              wr_acc;
    logic              rd_acc;
    logic              hit_status;
    logic              hit_cnt_hi;
    logic              hit_cnt_lo;
    logic              hit_mod_hi;
    logic              hit_mod_lo;
    logic              wr_status;
    logic              rd_status;
    logic              rd_cnt_hi;
    logic              rd_cnt_lo;
    logic              wr_mod_hi;
    logic              wr_mod_lo;
    logic [7:0]        wbyte;

    logic              brk_lock;
    logic              clr_cmd;
    logic              run;
    logic              tick;
    logic              reach;
    logic              ovf_evt;
    logic              clear_ok;
    logic [CNT_W-1:0]  count;
    logic [CNT_W-1:0]  modulo;
    logic [7:0]        status_byte;

    // ------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------

    // One wait state: data captured, then answered
    assign req     = i_avs_read | i_avs_write;
    assign answer  = req & (bus_state_r == BUS_ANSWER);
    assign capture = req & (bus_state_r == BUS_IDLE);
    assign o_avs_waitrequest = req & ~answer;
    assign o_avs_readdata    = readdata_r;

    // Register access is refused in wait mode
    assign acc_ok = ~i_wait_mode;
    assign wr_acc = answer & i_avs_write & i_avs_byteenable[0] & acc_ok;
    assign rd_acc = answer & i_avs_read & acc_ok;
    assign wbyte  = i_avs_writedata[7:0];

    // Bus state machine
    always_comb begin
        bus_state_nxt = bus_state_r;
        case (bus_state_r)
            BUS_IDLE: begin
                if (req) begin
                    bus_state_nxt = BUS_ANSWER;
                end
            end
            BUS_ANSWER: begin
                bus_state_nxt = BUS_IDLE;
            end
            default: begin
                bus_state_nxt = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            bus_state_r <= BUS_IDLE;
        end else begin
            bus_state_r <= bus_state_nxt;
        end
    end

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    assign hit_status = (i_avs_address == OFS_STATUS);
    assign hit_cnt_hi = (i_avs_address == OFS_CNT_HI);
    assign hit_cnt_lo = (i_avs_address == OFS_CNT_LO);
    assign hit_mod_hi = (i_avs_address == OFS_MOD_HI);
    assign hit_mod_lo = (i_avs_address == OFS_MOD_LO);

    assign wr_status = wr_acc & hit_status;
    assign rd_status = rd_acc & hit_status;
    assign rd_cnt_hi = rd_acc & hit_cnt_hi;
    assign rd_cnt_lo = rd_acc & hit_cnt_lo;
    assign wr_mod_hi = wr_acc & hit_mod_hi;
    assign wr_mod_lo = wr_acc & hit_mod_lo;

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------

    // Clear bit always reads zero
    assign status_byte = {flag_r, ctrl_r.ie, ctrl_r.halt, 1'b0,
                          1'b0, ctrl_r.ps};

    // Read mux; unmapped or refused reads return zero
    always_comb begin
        rd_mux = '0;
        if (i_wait_mode) begin
            rd_mux = '0;
        end else if (hit_status) begin
            rd_mux[7:0] = status_byte;
        end else if (hit_cnt_hi) begin
            rd_mux[7:0] = count[15:8];
        end else if (hit_cnt_lo) begin
            rd_mux[7:0] = lo_held_r ? lo_buf_r : count[7:0];
        end else if (hit_mod_hi) begin
            rd_mux[7:0] = mod_hi_r;
        end else if (hit_mod_lo) begin
            rd_mux[7:0] = mod_lo_r;
        end
    end

    // Capture read data and a count snapshot
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            readdata_r <= '0;
            snap_r     <= RST_CNT;
        end else if (capture) begin
            readdata_r <= rd_mux;
            snap_r     <= count;
        end
    end

    // High byte read latches the low byte until low is read
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            lo_buf_r  <= 8'h00;
            lo_held_r <= 1'b0;
        end else if (rd_cnt_hi && !lo_held_r) begin
            lo_buf_r  <= snap_r[7:0];
            lo_held_r <= 1'b1;
        end else if (rd_cnt_lo) begin
            lo_held_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------

    // Enable, halt and rate select are plain read/write
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wr_status) begin
            ctrl_nxt.ie   = wbyte[BIT_IE];
            ctrl_nxt.halt = wbyte[BIT_HALT];
            ctrl_nxt.ps   = wbyte[PS_LSB +: PS_W];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            ctrl_r.ie   <= RST_IE;
            ctrl_r.halt <= RST_HALT;
            ctrl_r.ps   <= RST_PS;
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // Self-clearing counter clear strobe
    assign clr_cmd = wr_status & wbyte[BIT_CLR];

    // ------------------------------------------------------------
    // Modulo registers
    // ------------------------------------------------------------

    // High byte write blocks overflow until low byte lands
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            mod_hi_r  <= RST_MOD[15:8];
            mod_lo_r  <= RST_MOD[7:0];
            inhibit_r <= 1'b0;
        end else if (wr_mod_hi) begin
            mod_hi_r  <= wbyte;
            inhibit_r <= 1'b1;
        end else if (wr_mod_lo) begin
            mod_lo_r  <= wbyte;
            inhibit_r <= 1'b0;
        end
    end

    assign modulo = {mod_hi_r, mod_lo_r};

    // ------------------------------------------------------------
    // Counting path
    // ------------------------------------------------------------

    // Halt, stop mode and break all freeze the count
    assign run = ~ctrl_r.halt & ~i_stop_mode & ~i_break;

    perit_prescaler u_prescaler (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_clear (clr_cmd),
        .i_run   (run),
        .i_sel   (ctrl_r.ps),
        .o_tick  (tick)
    );

    perit_counter u_counter (
        .i_clk    (i_clk),
        .i_reset  (i_reset),
        .i_clear  (clr_cmd),
        .i_tick   (tick),
        .i_modulo (modulo),
        .o_count  (count),
        .o_reach  (reach)
    );

    // ------------------------------------------------------------
    // Overflow flag
    // ------------------------------------------------------------

    // Match sets the flag unless the modulo update is pending
    assign ovf_evt = reach & ~inhibit_r;

    // Break without clear enable blocks flag clearing and arming
    assign brk_lock = i_break & ~i_break_clear_enable;

    // Second step of the clear: write 0 after arming
    assign clear_ok = wr_status & ~wbyte[BIT_FLAG]
                      & arm_r & ~brk_lock;

    // Flag value returned by the read being answered
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            seen_flag_r <= 1'b0;
        end else if (capture) begin
            seen_flag_r <= flag_r;
        end
    end

    // Arm only on a flag that software was shown
    assign arm_set  = rd_status & seen_flag_r & ~brk_lock;
    assign arm_drop = wr_status & ~brk_lock;

    // Arming: set by a read seeing the flag, voided by overflow
    always_comb begin
        arm_nxt = arm_r;
        if (ovf_evt) begin
            arm_nxt = 1'b0;
        end else if (arm_set) begin
            arm_nxt = 1'b1;
        end else if (arm_drop) begin
            arm_nxt = 1'b0;
        end
    end

    // Set wins over clear; writing 1 never sets
    always_comb begin
        flag_nxt = flag_r;
        if (ovf_evt) begin
            flag_nxt = 1'b1;
        end else if (clear_ok) begin
            flag_nxt = 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            flag_r <= 1'b0;
            arm_r  <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
            arm_r  <= arm_nxt;
        end
    end

    // ------------------------------------------------------------
    // Interrupt request
    // ------------------------------------------------------------

    // Level request, also usable as wait-mode wake
    assign o_irq = flag_r & ctrl_r.ie;

endmodule

/* verif/perit_checker.sv */
`timescale 1ns/1ps
module perit_checker (
    input wire logic                         i_clk,
    input wire logic                         i_reset,
    input wire logic [perit_pkg::ADDR_W-1:0] i_avs_address,
    input wire logic                         i_avs_read,
    input wire logic                         i_avs_write,
    input wire logic [perit_pkg::DATA_W-1:0] o_avs_readdata,
    input wire logic                         o_avs_waitrequest,
    input wire logic                         i_wait_mode,
    input wire logic                         i_stop_mode,
    input wire logic                         o_irq
);
    import perit_pkg::*;
    // Request decode
    wire req = i_avs_read | i_avs_write;
    wire mapped = i_avs_address inside {OFS_STATUS, OFS_CNT_HI,
                  OFS_CNT_LO, OFS_MOD_HI, OFS_MOD_LO};
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    sequence s_start; req && !$past(req); endsequence
    sequence s_rd_done; i_avs_read && !o_avs_waitrequest; endsequence
    property p_wait_first; s_start |-> o_avs_waitrequest; endproperty
    property p_one_wait; s_start |=> !o_avs_waitrequest; endproperty
    property p_idle; !req |-> !o_avs_waitrequest; endproperty
    property p_upper; s_rd_done |-> o_avs_readdata[31:8] == 24'h0;
    endproperty
    property p_clr_zero;
        s_rd_done and i_avs_address == OFS_STATUS
        |-> !o_avs_readdata[BIT_CLR];
    endproperty
    property p_wait_refuse;
        s_rd_done and i_wait_mode && $past(i_wait_mode)
        |-> o_avs_readdata == 32'h0;
    endproperty
    property p_unmapped; s_rd_done and !mapped |-> o_avs_readdata == 32'h0;
    endproperty
    property p_stop_irq;
        i_stop_mode && $past(i_stop_mode) && $past(i_stop_mode, 2)
        && !i_avs_write && !$past(i_avs_write) |-> $stable(o_irq);
    endproperty
    property p_irq_reset; $past(i_reset) |-> !o_irq; endproperty
    a_wait_first: assert property (p_wait_first)
        else $error("no wait state in first cycle");
    a_one_wait: assert property (p_one_wait)
        else $error("more than one wait state");
    a_idle: assert property (p_idle)
        else $error("waitrequest without request");
    a_upper: assert property (p_upper)
        else $error("upper read bits not zero");
    a_clr_zero: assert property (p_clr_zero)
        else $error("clear bit reads one");
    a_wait_refuse: assert property (p_wait_refuse)
        else $error("read in wait mode not refused");
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    a_stop_irq: assert property (p_stop_irq)
        else $error("irq moved in stop mode");
    a_irq_reset: assert property (p_irq_reset)
        else $error("irq high after reset");
endmodule

bind perit_timer perit_checker perit_checker_inst (
    .i_clk(i_clk), .i_reset(i_reset), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .i_wait_mode(i_wait_mode), .i_stop_mode(i_stop_mode), .o_irq(o_irq)
);

/* verif/perit_cpu_model.sv */
`timescale 1ns/1ps
module perit_cpu_model (
    input  wire logic                         i_clk,
    input  wire logic [perit_pkg::DATA_W-1:0] i_readdata,
    input  wire logic                         i_waitrequest,
    output logic      [perit_pkg::ADDR_W-1:0] o_address,
    output logic                              o_read,
    output logic                              o_write,
    output logic      [perit_pkg::DATA_W-1:0] o_writedata,
    output logic      [3:0]                   o_byteenable
);
    import perit_pkg::*;
    // Idle bus at time zero
    initial begin
        o_address = '0;
        o_read = 1'b0;
        o_write = 1'b0;
        o_writedata = '0;
        o_byteenable = 4'h0;
    end
    // One access, held until waitrequest is seen low at an edge
    task automatic access(input logic w, input logic [ADDR_W-1:0] a,
                          input logic [7:0] d, output logic [7:0] q,
                          output logic ok);
        int n;
        n = 0;
        @(posedge i_clk);
        o_address <= a;
        o_read <= !w;
        o_write <= w;
        o_writedata <= {24'h0, d};
        o_byteenable <= 4'hf;
        do begin
            @(posedge i_clk);
            n++;
        end while (i_waitrequest !== 1'b0 && n < 50);
        q = i_readdata[7:0];
        ok = (i_waitrequest === 1'b0);
        o_read <= 1'b0;
        o_write <= 1'b0;
    endtask
endmodule

/* verif/perit_timer_tb.sv */
`timescale 1ns/1ps
module perit_timer_tb;
    import perit_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic              clk;
    logic              reset;
    logic              wait_m;
    logic              stop_m;
    logic              brk;
    logic              bce;
    logic [ADDR_W-1:0] adr;
    logic              rd;
    logic              wr;
    logic [DATA_W-1:0] wdat;
    logic [DATA_W-1:0] rdat;
    logic [3:0]        be;
    logic              wreq;
    logic              irq;
    logic [7:0]        q;
    int                n_mismatch;
    int                tests_run;

    perit_timer perit_timer_inst (
        .i_clk(clk), .i_reset(reset), .i_avs_address(adr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat),
        .i_avs_byteenable(be), .o_avs_readdata(rdat),
        .o_avs_waitrequest(wreq), .i_wait_mode(wait_m),
        .i_stop_mode(stop_m), .i_break(brk),
        .i_break_clear_enable(bce), .o_irq(irq)
    );
    perit_cpu_model perit_cpu_model_inst (
        .i_clk(clk), .i_readdata(rdat), .i_waitrequest(wreq),
        .o_address(adr), .o_read(rd), .o_write(wr),
        .o_writedata(wdat), .o_byteenable(be)
    );
    // Clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] s, e);
        tests_run++;
        if (s !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic rw(input logic w, input logic [ADDR_W-1:0] a,
                      input logic [7:0] d);
        logic ok;
        perit_cpu_model_inst.access(w, a, d, q, ok);
        if (!ok) begin
            n_mismatch++;
            summarize();
        end
    endtask
    task automatic pins(input logic w, s, b, e);
        @(posedge clk);
        wait_m <= w;
        stop_m <= s;
        brk <= b;
        bce <= e;
    endtask
    task automatic cnt(output logic [15:0] v);
        rw(0, OFS_CNT_HI, 8'h00);
        v[15:8] = q;
        rw(0, OFS_CNT_LO, 8'h00);
        v[7:0] = q;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rw(0, OFS_STATUS, 8'h00);
        chk("status rst", q, 8'h20);
        rw(0, OFS_MOD_LO, 8'h00);
        chk("mod rst", q, 8'hff);
        rw(1, 5'h14, 8'h5a);
        rw(0, 5'h14, 8'h00);
        chk("unmapped", q, 8'h00);
        $display("done reset");
    endtask
    task automatic t_prescale();
        logic [15:0] a;
        logic [15:0] b;
        for (int s = 0; s < 8; s++) begin
            int d;
            d = (s == 7) ? 64 : (1 << s);
            rw(1, OFS_STATUS, 8'h30 | s[7:0]);
            rw(1, OFS_STATUS, s[7:0]);
            repeat (128) @(posedge clk);
            rw(1, OFS_STATUS, 8'h20 | s[7:0]);
            rw(0, OFS_STATUS, 8'h00);
            chk("ps field", q, 8'h20 | s[7:0]);
            cnt(a);
            chk("rate", a >= 128 / d && a <= 136 / d + 1, 1);
            repeat (20) @(posedge clk);
            cnt(b);
            chk("halt hold", b, a);
        end
        rw(1, OFS_STATUS, 8'h30);
        cnt(a);
        chk("clear", a, 16'h0000);
        $display("done prescale");
    endtask
    task automatic t_modulo();
        int n;
        logic [15:0] a;
        rw(1, OFS_STATUS, 8'h70);
        rw(1, OFS_MOD_HI, 8'h00);
        rw(1, OFS_MOD_LO, 8'h03);
        rw(1, OFS_STATUS, 8'h40);
        n = 0;
        while (irq !== 1'b1 && n < 40) begin
            @(posedge clk);
            n++;
        end
        chk("reach time", n >= 2 && n <= 5, 1);
        rw(1, OFS_STATUS, 8'h60);
        cnt(a);
        chk("wrap", a <= 3, 1);
        rw(0, OFS_STATUS, 8'h00);
        chk("unarmed clear", q, 8'he0);
        rw(1, OFS_STATUS, 8'ha0);
        rw(0, OFS_STATUS, 8'h00);
        chk("write one", q, 8'ha0);
        chk("irq masked", irq, 1'b0);
        rw(1, OFS_STATUS, 8'h60);
        rw(0, OFS_STATUS, 8'h00);
        chk("cleared", q, 8'h60);
        chk("irq off", irq, 1'b0);
        rw(1, OFS_MOD_HI, 8'h00);
        rw(1, OFS_STATUS, 8'h40);
        repeat (20) @(posedge clk);
        rw(0, OFS_STATUS, 8'h00);
        chk("mod inhibit", q, 8'h40);
        rw(1, OFS_MOD_LO, 8'h03);
        repeat (20) @(posedge clk);
        rw(1, OFS_STATUS, 8'h60);
        rw(0, OFS_STATUS, 8'h00);
        chk("mod release", q, 8'he0);
        rw(1, OFS_STATUS, 8'h60);
        $display("done modulo");
    endtask
    task automatic t_busy();
        rw(1, OFS_STATUS, 8'h30);
        rw(1, OFS_MOD_LO, 8'h00);
        rw(1, OFS_STATUS, 8'h00);
        rw(0, OFS_STATUS, 8'h00);
        rw(1, OFS_STATUS, 8'h40);
        rw(0, OFS_STATUS, 8'h00);
        chk("refire", q, 8'hc0);
        pins(1, 0, 0, 0); // counter kept running to wake
        rw(0, OFS_STATUS, 8'h00);
        chk("wait read", q, 8'h00);
        rw(1, OFS_STATUS, 8'h20);
        chk("wake irq", irq, 1'b1);
        pins(0, 0, 0, 0);
        rw(0, OFS_STATUS, 8'h00);
        chk("wait write", q, 8'hc0);
        rw(1, OFS_STATUS, 8'h20);
        rw(0, OFS_STATUS, 8'h00);
        pins(0, 0, 1, 0);
        rw(1, OFS_STATUS, 8'h20);
        rw(0, OFS_STATUS, 8'h00);
        chk("locked", q, 8'ha0);
        pins(0, 0, 0, 0);
        rw(1, OFS_STATUS, 8'h20);
        rw(0, OFS_STATUS, 8'h00);
        chk("after break", q, 8'h20);
        rw(1, OFS_STATUS, 8'h00);
        rw(1, OFS_STATUS, 8'h20);
        pins(0, 0, 1, 1);
        rw(0, OFS_STATUS, 8'h00);
        rw(1, OFS_STATUS, 8'h20);
        pins(0, 0, 0, 0);
        rw(0, OFS_STATUS, 8'h00);
        chk("break clear", q, 8'h20);
        $display("done busy");
    endtask
    task automatic t_freeze();
        logic [15:0] a;
        logic [15:0] b;
        rw(1, OFS_MOD_HI, 8'hff);
        rw(1, OFS_MOD_LO, 8'hff);
        rw(1, OFS_STATUS, 8'h10);
        for (int k = 0; k < 2; k++) begin
            pins(0, k == 0, k == 1, 0);
            cnt(a);
            repeat (10) @(posedge clk);
            cnt(b);
            chk("frozen", b, a);
            pins(0, 0, 0, 0);
            repeat (10) @(posedge clk);
            cnt(b);
            chk("resumed", b > a, 1);
        end
        $display("done freeze");
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        n_mismatch = 0;
        tests_run = 0;
        reset = 1'b1;
        wait_m = 1'b0;
        stop_m = 1'b0;
        brk = 1'b0;
        bce = 1'b0;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        t_reset();
        t_prescale();
        t_modulo();
        t_busy();
        t_freeze();
        summarize();
    end
endmodule
